// file: rtl/rstc_defs.svh
// constants of the multi source reset controller: offsets, fields, resets, counts
// assumes byte addressing on the register bus, one 32-bit word per register
`ifndef RSTC_DEFS_SVH
`define RSTC_DEFS_SVH

`define RSTC_CNT_W 11
`define RSTC_CFG_W 14
`define RSTC_SRC_W 6
`define RSTC_SYNC_W 18

// release delays in cycles of the input clock and reference clock
`define RSTC_POR_DLY_CYC 11'd1024
`define RSTC_HARD_REL_CYC 11'd512
`define RSTC_SOFT_REL_CYC 11'd515

`define RSTC_OFS_STATUS 5'h00
`define RSTC_OFS_CTRL 5'h04
`define RSTC_OFS_CFG 5'h08
`define RSTC_OFS_HRCW 5'h0C
`define RSTC_OFS_HRCW_ACT 5'h10
`define RSTC_OFS_STATE 5'h14

`define RSTC_SRC_POR 0
`define RSTC_SRC_HARD 1
`define RSTC_SRC_SOFT 2
`define RSTC_SRC_WDOG 3
`define RSTC_SRC_BUSMON 4
`define RSTC_SRC_HOST 5

`define RSTC_CTRL_WDOG_EN 0
`define RSTC_CTRL_BUSMON_EN 1
`define RSTC_CTRL_HOST_CMD 2

`define RSTC_STATUS_RST 6'h01
`define RSTC_CTRL_RST 2'h0
`define RSTC_HRCW_RST 32'h00000000
`define RSTC_CFG_RST 14'h0000

`endif

// file: rtl/rstc_pkg.sv
// types of the multi source reset controller
// assumes rstc_defs.svh on the include path
`include "rstc_defs.svh"

package rstc_pkg;

	// gray along por_hold, por_wait, pll_wait, hard_rel, run
	typedef enum logic [2:0] {
		RSTC_POR_HOLD = 3'h0,
		RSTC_POR_WAIT = 3'h1,
		RSTC_PLL_WAIT = 3'h3,
		RSTC_HARD_REL = 3'h2,
		RSTC_RUN = 3'h6,
		RSTC_SOFT = 3'h7,
		RSTC_HARD_EXT = 3'h4
	} rstc_state_t;

	typedef struct packed {
		rstc_state_t state;
		logic [`RSTC_CNT_W-1:0] cnt;
		logic hard_oe;
		logic soft_oe;
		logic pll_reset;
		logic sys_reset;
		logic core_reset;
		logic armed;
		logic [`RSTC_CFG_W-1:0] cfg;
		logic [31:0] hrcw;
		logic [31:0] hrcw_act;
		logic [`RSTC_SRC_W-1:0] status;
		logic [1:0] ctrl;
		logic host_cmd;
		logic waitreq;
		logic [31:0] rdata;
	} rstc_regs_t;

endpackage

// file: rtl/rstc_sync.sv
// two flip-flop synchroniser bank for pins and foreign-domain levels
// assumes each bit is a slow level; no bus coherency between bits
`timescale 1ns/1ns

module rstc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end

endmodule

// file: rtl/rstc_ctrl.sv
// multi source reset controller: sequences power-on, hard and soft resets
// assumes clk_sys_i stands in for input and reference clock; pins are asynchronous
//
// Function
// - all six reset sources feed one controller choosing actions per source
// - readable status register names the source or sources of latest reset
// - power-on resets everything incl. PLL, drives both pins, samples configuration
// - clock, boot, reset mode, chip id and width choice latched at power-on only
// - soft reset pin held asserted whenever hard reset pin is asserted
// - hard reset pin is open-drain; device only pulls low or releases
// - hard reset drives both pins, resets cores, loads 32-bit configuration word
// - external soft reset accepted only while device asserts no reset
// - soft reset pin is open-drain; device only pulls low or releases
// - soft reset drives soft pin, resets cores, keeps established configuration
// - enabled watchdog reaching zero records event and starts internal hard reset
// - enabled bus monitor reaching zero starts internal hard reset
// - host command through test port starts internal soft reset
// - internal power-on reset released 1024 input clocks after pin release
// - after PLL lock, hard pin released at 512, soft at 515 clocks
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns

module rstc_ctrl
	import rstc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic power_on_reset_pin_n_i,
	input wire logic hard_reset_pin_n_i,
	output logic hard_reset_pin_n_o,
	output logic hard_reset_pin_oe_o,
	input wire logic soft_reset_pin_n_i,
	output logic soft_reset_pin_n_o,
	output logic soft_reset_pin_oe_o,
	input wire logic [`RSTC_CFG_W-1:0] cfg_pins_i,
	input wire logic system_pll_lock_i,
	input wire logic wdog_expire_i,
	input wire logic busmon_expire_i,
	input wire logic tap_soft_cmd_i,
	output logic system_pll_reset_o,
	output logic sys_reset_o,
	output logic core_reset_o,
	output logic [`RSTC_CFG_W-1:0] cfg_o,
	output logic [31:0] hrcw_o,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);

	//////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [`RSTC_SYNC_W-1:0] sync_q;
	logic por_n_s;
	logic hard_n_s;
	logic soft_n_s;
	logic lock_s;
	logic [`RSTC_CFG_W-1:0] cfg_s;

	rstc_sync #(
		.W(`RSTC_SYNC_W),
		.RST_VAL({4'h6, `RSTC_CFG_RST})
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.d_i({power_on_reset_pin_n_i, hard_reset_pin_n_i, soft_reset_pin_n_i,
			system_pll_lock_i, cfg_pins_i}),
		.q_o(sync_q)
	);

	assign {por_n_s, hard_n_s, soft_n_s, lock_s, cfg_s} = sync_q;

	//////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic cnt_done(input logic [`RSTC_CNT_W-1:0] c,
		input logic [`RSTC_CNT_W-1:0] lim);
		return c == lim - `RSTC_CNT_W'(1);
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// state

	rstc_regs_t st;
	rstc_regs_t next_st;

	logic wdog_hit;
	logic busmon_hit;
	logic ext_hard_hit;
	logic ext_soft_hit;
	logic host_hit;
	logic hard_any;
	logic soft_any;
	logic bus_req;
	logic bus_take;
	logic [31:0] rd_mux;

	assign wdog_hit = wdog_expire_i && st.ctrl[`RSTC_CTRL_WDOG_EN];
	assign busmon_hit = busmon_expire_i && st.ctrl[`RSTC_CTRL_BUSMON_EN];
	// pins read only once both were seen high after our own release
	assign ext_hard_hit = !hard_n_s && st.armed;
	assign ext_soft_hit = !soft_n_s && st.armed && st.state == RSTC_RUN;
	assign host_hit = tap_soft_cmd_i || st.host_cmd;
	assign hard_any = wdog_hit || busmon_hit || ext_hard_hit;
	assign soft_any = ext_soft_hit || host_hit;
	assign bus_req = avs_read_i || avs_write_i;
	assign bus_take = bus_req && !st.waitreq;

	always_comb begin
		case (avs_address_i)
			`RSTC_OFS_STATUS: rd_mux = {26'h0000000, st.status};
			`RSTC_OFS_CTRL: rd_mux = {30'h00000000, st.ctrl};
			`RSTC_OFS_CFG: rd_mux = {18'h00000, st.cfg};
			`RSTC_OFS_HRCW: rd_mux = st.hrcw;
			`RSTC_OFS_HRCW_ACT: rd_mux = st.hrcw_act;
			`RSTC_OFS_STATE: rd_mux = {29'h00000000, st.state};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.host_cmd = 1'b0;

		// one wait cycle, then the request is taken
		next_st.waitreq = !(bus_req && st.waitreq);
		if (bus_req && st.waitreq) begin
			next_st.rdata = avs_read_i ? rd_mux : 32'h00000000;
		end
		if (bus_take && avs_write_i) begin
			case (avs_address_i)
				`RSTC_OFS_CTRL: begin
					if (avs_byteenable_i[0]) begin
						next_st.ctrl = avs_writedata_i[1:0];
						next_st.host_cmd = avs_writedata_i[`RSTC_CTRL_HOST_CMD];
					end
				end
				`RSTC_OFS_HRCW: next_st.hrcw = be_merge(st.hrcw, avs_writedata_i,
					avs_byteenable_i);
				default: ;
			endcase
		end

		if (hard_n_s && soft_n_s && !st.hard_oe && !st.soft_oe) begin
			next_st.armed = 1'b1;
		end
		if (st.state != rstc_state_t'(RSTC_POR_HOLD)) begin
			next_st.cnt = st.cnt + `RSTC_CNT_W'(1);
		end

		case (st.state)
			RSTC_POR_HOLD: begin
				next_st.cnt = '0;
				if (por_n_s) begin
					next_st.state = RSTC_POR_WAIT;
					next_st.cfg = cfg_s;
				end
			end
			RSTC_POR_WAIT: begin
				if (cnt_done(st.cnt, `RSTC_POR_DLY_CYC)) begin
					next_st.state = RSTC_PLL_WAIT;
					next_st.pll_reset = 1'b0;
				end
			end
			RSTC_PLL_WAIT: begin
				next_st.cnt = '0;
				if (lock_s) begin
					next_st.state = RSTC_HARD_REL;
					next_st.hrcw_act = st.hrcw;
				end
			end
			RSTC_HARD_REL: begin
				if (cnt_done(st.cnt, `RSTC_HARD_REL_CYC)) begin
					next_st.hard_oe = 1'b0;
					next_st.sys_reset = 1'b0;
				end
				if (cnt_done(st.cnt, `RSTC_SOFT_REL_CYC)) begin
					next_st.soft_oe = 1'b0;
					next_st.core_reset = 1'b0;
					next_st.state = RSTC_RUN;
				end
			end
			RSTC_HARD_EXT: begin
				next_st.cnt = '0;
				// another party pulls the pin; take over once it lets go
				if (hard_n_s) begin
					next_st.state = RSTC_HARD_REL;
					next_st.hard_oe = 1'b1;
					next_st.hrcw_act = st.hrcw;
				end
			end
			RSTC_SOFT: begin
				if (cnt_done(st.cnt, `RSTC_SOFT_REL_CYC)) begin
					next_st.soft_oe = 1'b0;
					next_st.core_reset = 1'b0;
					next_st.state = RSTC_RUN;
				end
			end
			RSTC_RUN: begin
				next_st.cnt = '0;
			end
			default: begin
				next_st.state = RSTC_POR_HOLD;
			end
		endcase

		// hard beats soft; soft runs only from the idle state
		if ((st.state == RSTC_RUN || st.state == RSTC_SOFT) && hard_any) begin
			next_st.cnt = '0;
			next_st.armed = 1'b0;
			next_st.status = '0;
			next_st.status[`RSTC_SRC_HARD] = ext_hard_hit;
			next_st.status[`RSTC_SRC_WDOG] = wdog_hit;
			next_st.status[`RSTC_SRC_BUSMON] = busmon_hit;
			next_st.soft_oe = 1'b1;
			next_st.sys_reset = 1'b1;
			next_st.core_reset = 1'b1;
			if (wdog_hit || busmon_hit) begin
				next_st.state = RSTC_HARD_REL;
				next_st.hard_oe = 1'b1;
				next_st.hrcw_act = st.hrcw;
			end else begin
				next_st.state = RSTC_HARD_EXT;
			end
		end else if (st.state == RSTC_RUN && soft_any) begin
			next_st.cnt = '0;
			next_st.armed = 1'b0;
			next_st.status = '0;
			next_st.status[`RSTC_SRC_SOFT] = ext_soft_hit;
			next_st.status[`RSTC_SRC_HOST] = host_hit;
			next_st.state = RSTC_SOFT;
			next_st.soft_oe = 1'b1;
			next_st.core_reset = 1'b1;
		end

		if (!por_n_s) begin
			next_st.state = RSTC_POR_HOLD;
			next_st.cnt = '0;
			next_st.armed = 1'b0;
			next_st.status = `RSTC_STATUS_RST;
			next_st.hard_oe = 1'b1;
			next_st.soft_oe = 1'b1;
			next_st.pll_reset = 1'b1;
			next_st.sys_reset = 1'b1;
			next_st.core_reset = 1'b1;
			next_st.ctrl = `RSTC_CTRL_RST;
			next_st.hrcw = `RSTC_HRCW_RST;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '{state: RSTC_POR_HOLD, cnt: '0, hard_oe: 1'b1, soft_oe: 1'b1,
				pll_reset: 1'b1, sys_reset: 1'b1, core_reset: 1'b1, armed: 1'b0,
				cfg: `RSTC_CFG_RST, hrcw: `RSTC_HRCW_RST, hrcw_act: `RSTC_HRCW_RST,
				status: `RSTC_STATUS_RST, ctrl: `RSTC_CTRL_RST, host_cmd: 1'b0,
				waitreq: 1'b1, rdata: 32'h00000000};
		end else begin
			st <= next_st;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// outputs

	// open drain: data is always low, only the enable moves
	assign hard_reset_pin_n_o = 1'b0;
	assign soft_reset_pin_n_o = 1'b0;
	assign hard_reset_pin_oe_o = st.hard_oe;
	assign soft_reset_pin_oe_o = st.soft_oe;
	assign system_pll_reset_o = st.pll_reset;
	assign sys_reset_o = st.sys_reset;
	assign core_reset_o = st.core_reset;
	assign cfg_o = st.cfg;
	assign hrcw_o = st.hrcw_act;
	assign avs_readdata_o = st.rdata;
	assign avs_waitrequest_o = st.waitreq;

	//////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	chk_soft_with_hard: assert property (
		st.hard_oe |-> st.soft_oe
	) else $error("hard reset pin driven without soft reset pin");

	chk_por_all_reset: assert property (
		st.state == RSTC_POR_HOLD |-> st.hard_oe && st.pll_reset && st.core_reset
	) else $error("power-on hold without full reset");

	chk_por_release: assert property (
		st.state == RSTC_POR_WAIT && st.cnt == 11'd1023 |=> !st.pll_reset
			&& st.state == RSTC_PLL_WAIT
	) else $error("internal power-on not released after 1024 cycles");

	chk_por_hold_cnt: assert property (
		st.state == RSTC_POR_WAIT && st.cnt < 11'd1023 |=> st.pll_reset
	) else $error("internal power-on released early");

	chk_hard_rel_cnt: assert property (
		$fell(st.hard_oe) && por_n_s |-> $past(st.cnt) == 11'd511
			&& $past(st.state) == RSTC_HARD_REL
	) else $error("hard reset pin released at wrong count");

	chk_soft_rel_cnt: assert property (
		$fell(st.soft_oe) |-> $past(st.cnt) == 11'd514
	) else $error("soft reset pin released at wrong count");

	chk_cfg_por_only: assert property (
		!$stable(st.cfg) |-> $past(st.state) == RSTC_POR_HOLD
	) else $error("configuration latched outside power-on");

	chk_wdog_hard: assert property (
		st.state == RSTC_RUN && wdog_hit && por_n_s |=> st.state == RSTC_HARD_REL
			&& st.hard_oe && st.status[`RSTC_SRC_WDOG]
	) else $error("watchdog did not start a hard reset");

	chk_busmon_hard: assert property (
		st.state == RSTC_RUN && busmon_hit && por_n_s |=> st.hard_oe ##1 st.hard_oe
	) else $error("bus monitor did not drive hard reset");

	chk_soft_gate: assert property (
		st.state == RSTC_SOFT && $past(st.state) != RSTC_SOFT && st.status[`RSTC_SRC_SOFT]
			|-> $past(st.state) == RSTC_RUN && !$past(st.hard_oe) && !$past(st.soft_oe)
	) else $error("external soft reset taken while reset asserted");

	chk_soft_keeps_cfg: assert property (
		st.state == RSTC_SOFT && !hard_any |=> $stable(st.hrcw_act) && $stable(st.cfg)
	) else $error("soft reset changed configuration");

	chk_hrcw_load: assert property (
		$past(st.state) != RSTC_HARD_REL && st.state == RSTC_HARD_REL
			|-> st.hrcw_act == $past(st.hrcw)
	) else $error("hard reset did not load configuration word");

	chk_host_soft: assert property (
		st.state == RSTC_RUN && tap_soft_cmd_i && !hard_any && por_n_s
			|=> st.state == RSTC_SOFT && st.soft_oe [*2]
	) else $error("host command did not start soft reset");

endmodule

// file: dv/rstc_board.sv
// board side model: power pin, pulled-up open-drain reset wires, pll lock
// assumes the device presents each reset pin as data plus output enable
`timescale 1ns/1ns

module rstc_board #(
	parameter int LOCK_CYC = 40
) (
	input wire logic clk_sys_i,
	input wire logic por_req_i,
	input wire logic hard_pull_i,
	input wire logic soft_pull_i,
	input wire logic hard_d_i,
	input wire logic hard_oe_i,
	input wire logic soft_d_i,
	input wire logic soft_oe_i,
	input wire logic pll_reset_i,
	output logic power_n_o,
	output logic hard_wire_n_o,
	output logic soft_wire_n_o,
	output logic lock_o
);
	int por_cnt = 0;
	int lock_cnt = 0;
	logic hard_pull = 1'b0;
	logic soft_pull = 1'b0;

	initial begin
		power_n_o = 1'b0;
		lock_o = 1'b0;
	end

	always @(posedge clk_sys_i) begin
		// power pin stays low at least 16 clocks once pulled
		por_cnt <= power_n_o ? 0 : por_cnt + 1;
		power_n_o <= !(por_req_i || (!power_n_o && por_cnt < 16));
		// lock comes a while after the pll leaves reset
		lock_cnt <= pll_reset_i ? 0 : lock_cnt + 1;
		lock_o <= !pll_reset_i && lock_cnt >= LOCK_CYC;
		hard_pull <= hard_pull_i;
		soft_pull <= soft_pull_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// pulled-up wires: any party may pull low, none drives high
	assign hard_wire_n_o = !((hard_oe_i && !hard_d_i) || hard_pull);
	assign soft_wire_n_o = !((soft_oe_i && !soft_d_i) || soft_pull);
endmodule

// file: dv/rstc_ctrl_tb_top.sv
// self-checking bench of the reset controller against a model in integers
// assumes the board model in rstc_board.sv and the design in rtl/
`timescale 1ns/1ns

module rstc_ctrl_tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_n_i, por_req, hard_pull, soft_pull, power_on_reset_pin_n_i, system_pll_lock_i;
	logic hard_reset_pin_n_i, hard_reset_pin_n_o, hard_reset_pin_oe_o;
	logic soft_reset_pin_n_i, soft_reset_pin_n_o, soft_reset_pin_oe_o;
	logic wdog_expire_i, busmon_expire_i, tap_soft_cmd_i;
	logic system_pll_reset_o, sys_reset_o, core_reset_o;
	logic [13:0] cfg_pins_i, cfg_o, exp_cfg;
	logic [31:0] hrcw_o, avs_writedata_i, avs_readdata_o, exp_hrcw;
	logic [4:0] avs_address_i;
	logic [3:0] avs_byteenable_i;
	logic avs_read_i, avs_write_i, avs_waitrequest_o;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;

	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	rstc_ctrl u_dut (.clk_sys_i, .rst_n_i, .power_on_reset_pin_n_i, .hard_reset_pin_n_i,
		.hard_reset_pin_n_o, .hard_reset_pin_oe_o, .soft_reset_pin_n_i, .soft_reset_pin_n_o,
		.soft_reset_pin_oe_o, .cfg_pins_i, .system_pll_lock_i, .wdog_expire_i,
		.busmon_expire_i, .tap_soft_cmd_i, .system_pll_reset_o, .sys_reset_o, .core_reset_o,
		.cfg_o, .hrcw_o, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o);

	rstc_board u_board (.clk_sys_i, .por_req_i(por_req), .hard_pull_i(hard_pull),
		.soft_pull_i(soft_pull), .hard_d_i(hard_reset_pin_n_o), .hard_oe_i(hard_reset_pin_oe_o),
		.soft_d_i(soft_reset_pin_n_o), .soft_oe_i(soft_reset_pin_oe_o),
		.pll_reset_i(system_pll_reset_o), .power_n_o(power_on_reset_pin_n_i),
		.hard_wire_n_o(hard_reset_pin_n_i), .soft_wire_n_o(soft_reset_pin_n_i),
		.lock_o(system_pll_lock_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys_i);
		avs_read_i <= !wr;
		avs_write_i <= wr;
		avs_address_i <= a;
		avs_writedata_i <= d;
		do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	// counts pin drive cycles of one sequence; pulls a wire while the soft drive count ns is pull_at to pull_at+4
	task automatic run_seq(input int pull_at, input logic hw, output int nh, output int ns,
		output logic [1:0] rs);
		nh = 0;
		ns = 0;
		rs = 2'b00;
		while (!(ns > 0 && soft_reset_pin_oe_o === 1'b0)) begin
			@(negedge clk_sys_i);
			if (hard_reset_pin_oe_o === 1'b1) nh++;
			if (soft_reset_pin_oe_o === 1'b1) ns++;
			if (ns == 10) rs = {sys_reset_o, core_reset_o};
			if (hw) hard_pull <= (ns >= pull_at && ns < pull_at + 5);
			else soft_pull <= (ns >= pull_at && ns < pull_at + 5);
		end
	endtask

	task automatic post(input logic [31:0] st);
		logic [31:0] q;
		bus(1'b0, 5'h00, 32'h0, q);
		chk(q, st, "status");
		chk(cfg_o, exp_cfg, "cfg kept");
		chk(hrcw_o, exp_hrcw, "word");
		bus(1'b0, 5'h10, 32'h0, q);
		chk(q, exp_hrcw, "word reg");
		bus(1'b0, 5'h14, 32'h0, q);
		chk(q, 32'h6, "state run");
	endtask

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			$display("unexpected at %0t: timeout", $time);
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] q;
		int nh, ns, n;
		logic [1:0] rs;
		{rst_n_i, hard_pull, soft_pull, wdog_expire_i, busmon_expire_i, tap_soft_cmd_i} = '0;
		{avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
		avs_byteenable_i = 4'hF;
		por_req = 1'b1;
		void'($urandom(33));
		cfg_pins_i = 14'($urandom);
		exp_cfg = cfg_pins_i;
		exp_hrcw = 32'h0;
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (20) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk({system_pll_reset_o, sys_reset_o, core_reset_o, hard_reset_pin_oe_o,
			soft_reset_pin_oe_o}, 5'h1F, "por hold");
		@(posedge clk_sys_i);
		por_req <= 1'b0;
		n = 0;
		do @(negedge clk_sys_i); while (power_on_reset_pin_n_i !== 1'b1);
		while (system_pll_reset_o !== 1'b0) begin
			@(negedge clk_sys_i);
			n++;
		end
		chk(n >= 1024 && n <= 1030, 1, "por release");
		@(posedge clk_sys_i);
		cfg_pins_i <= ~exp_cfg;
		do @(negedge clk_sys_i); while (system_pll_lock_i !== 1'b1);
		run_seq(-9, 1'b0, nh, ns, rs);
		chk(nh >= 512 && nh <= 516, 1, "hard release");
		chk(ns - nh, 3, "soft after hard");
		chk(cfg_o, exp_cfg, "straps");
		bus(1'b0, 5'h08, 32'h0, q);
		chk(q, exp_cfg, "cfg reg");
		post(32'h01);
		exp_hrcw = $urandom;
		bus(1'b1, 5'h0C, exp_hrcw, q);
		bus(1'b0, 5'h0C, 32'h0, q);
		chk(q, exp_hrcw, "hrcw rw");
		avs_byteenable_i <= 4'h3;
		bus(1'b1, 5'h0C, ~exp_hrcw, q);
		avs_byteenable_i <= 4'hF;
		exp_hrcw[15:0] = ~exp_hrcw[15:0];
		bus(1'b0, 5'h0C, 32'h0, q);
		chk(q, exp_hrcw, "hrcw bytes");
		bus(1'b0, 5'h1C, 32'h0, q);
		chk(q, 0, "unmapped");
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, 5'h04, 32'(1 << i), q);
			bus(1'b0, 5'h04, 32'h0, q);
			chk(q, 32'(1 << i), "ctrl");
			@(posedge clk_sys_i);
			wdog_expire_i <= (i == 0);
			busmon_expire_i <= (i == 1);
			@(posedge clk_sys_i);
			wdog_expire_i <= 1'b0;
			busmon_expire_i <= 1'b0;
			run_seq(100, 1'b0, nh, ns, rs);
			chk(nh, 512, "hard span");
			chk(ns, 515, "soft span");
			chk(rs, 2'b11, "domains");
			post(32'(8 << i));
			repeat (20) @(negedge clk_sys_i);
			chk(soft_reset_pin_oe_o, 1'b0, "late pull ignored");
		end
		bus(1'b1, 5'h04, 32'h0, q);
		@(posedge clk_sys_i);
		wdog_expire_i <= 1'b1;
		busmon_expire_i <= 1'b1;
		@(posedge clk_sys_i);
		wdog_expire_i <= 1'b0;
		busmon_expire_i <= 1'b0;
		repeat (10) @(negedge clk_sys_i);
		chk(hard_reset_pin_oe_o, 1'b0, "disabled");
		for (int i = 0; i < 3; i++) begin
			if (i == 1) begin
				bus(1'b1, 5'h04, 32'h4, q);
			end else begin
				@(posedge clk_sys_i);
				tap_soft_cmd_i <= (i == 0);
				@(posedge clk_sys_i);
				tap_soft_cmd_i <= 1'b0;
			end
			run_seq(i == 2 ? 0 : -9, 1'b0, nh, ns, rs);
			chk(nh, 0, "no hard");
			chk(i == 2 ? ns >= 515 : ns == 515, 1, "soft span");
			chk(rs, 2'b01, "cores only");
			post(i == 2 ? 32'h04 : 32'h20);
		end
		run_seq(0, 1'b1, nh, ns, rs);
		chk(nh, 512, "ext hard span");
		chk(ns >= 517, 1, "soft with hard");
		chk(rs, 2'b11, "domains");
		post(32'h02);
		report_and_stop();
	end
endmodule
